// [rtl/dsp_pkg.sv]
// Purpose: shared constants, carriers and state types of the burst-of-two DDR port
// Assumes: 10 MHz system clock; link clock is the true input clock of the port
// Notes: the wide (36-bit) organisation sets the port widths; narrow uses the low lanes
package dsp_pkg;
   // =====================================================
   // organisation
   localparam int DATA_W = 36;
   localparam int LANE_W = 9;
   localparam int LANES = 4;
   localparam logic [LANES-1:0] NARROW_LANE_MASK = 4'h3;
   localparam logic [LANES-1:0] WIDE_LANE_MASK = 4'hf;
   localparam int ADDR_W = 20;
   // =====================================================
   // write buffer
   localparam int FIFO_DEPTH = 8;
   localparam int FIFO_LVL_W = 4;
   // two writes may already be in flight when a new one is judged
   localparam logic [FIFO_LVL_W-1:0] FIFO_ROOM = 4'(FIFO_DEPTH - 3);
   // =====================================================
   // timing
   localparam int SYS_CLK_PERIOD_NS = 100;
   localparam int LOCK_TIME_US = 20;
   localparam int LOCK_CNT_W = 8;
   localparam logic [LOCK_CNT_W-1:0] LOCK_CYC =
      LOCK_CNT_W'((LOCK_TIME_US * 1000 + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS);
   localparam int MIN_K_FREQ_MHZ = 120;
   localparam int ALIVE_DIV_W = 5;
   localparam int GAP_CNT_W = 4;
   localparam logic [GAP_CNT_W-1:0] GAP_CYC = 4'h8;
   // =====================================================
   // carriers and states
   typedef struct packed {
      logic load_strobe_n;
      logic read_write;
      logic [ADDR_W-1:0] addr;
   } dsp_cmd_s;
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] d0;
      logic [LANES-1:0] en0;
      logic [DATA_W-1:0] d1;
      logic [LANES-1:0] en1;
   } dsp_wr_s;
   typedef enum logic [1:0] {LK_WAIT, LK_COUNT, LK_LOCKED, LK_BYPASS} dsp_lock_e;
endpackage

// [rtl/dsp_port.sv]
// Purpose: device-side logic of a burst-of-two DDR static RAM port with separate I/O
// Assumes: K# is the complement of K, so a K# rise is taken as the K fall
// Notes: lock tracking runs on sys_clk_i, everything at the link runs on k_clk_i
`timescale 1ns/100ps
`default_nettype none

module dsp_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input wire logic clk_i,                       // fifo clock
   input wire logic rst_i,                       // async reset, high
   input wire logic in_valid_i,                  // push request
   output logic in_ready_o,                      // room for a word
   input wire logic [WIDTH-1:0] in_data_i,       // pushed word
   output logic out_valid_o,                     // word available
   input wire logic out_ready_i,                 // drain accepts
   output logic [WIDTH-1:0] out_data_o,          // head word
   output logic [$clog2(DEPTH+1)-1:0] level_o    // words held
);
   localparam int PW = $clog2(DEPTH);
   logic [WIDTH-1:0] store [DEPTH];
   logic [PW-1:0] wr_ptr;
   logic [PW-1:0] rd_ptr;
   logic push;
   logic pop;

   assign in_ready_o = (level_o != ($clog2(DEPTH+1))'(DEPTH));
   assign out_valid_o = (level_o != '0);
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;
   assign out_data_o = store[rd_ptr];

   // depth must be a power of two for the wrapping pointers
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         level_o <= '0;
      end
      else
      begin
         if (push)
            wr_ptr <= wr_ptr + 1'b1;
         if (pop)
            rd_ptr <= rd_ptr + 1'b1;
         if (push && !pop)
            level_o <= level_o + 1'b1;
         else if (pop && !push)
            level_o <= level_o - 1'b1;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (push)
         store[wr_ptr] <= in_data_i;
   end

   a_fifo_no_underflow: assert property (@(posedge clk_i) disable iff (rst_i)
      pop |-> level_o != '0)
      else $error("fifo popped while empty");
endmodule // dsp_fifo

module dsp_port #(
   parameter bit wide_org_p = 1'b1,              // 1: 36-bit, 0: 18-bit organisation
   parameter int store_aw_p = dsp_pkg::ADDR_W    // implemented burst address bits
) (
   input wire logic sys_clk_i,                   // system clock, 10 MHz
   input wire logic sys_rst_i,                   // async reset, high
   input wire logic k_clk_i,                     // true input clock (link)
   input wire dsp_pkg::dsp_cmd_s cmd_i,          // strobe, select, address
   input wire logic [dsp_pkg::DATA_W-1:0] d_i,   // write data, both K edges
   input wire logic lane0_write_n_i,             // lane 0 enable, low
   input wire logic lane1_write_n_i,             // lane 1 enable, low
   input wire logic lane2_write_n_i,             // lane 2 enable, low
   input wire logic lane3_write_n_i,             // lane 3 enable, low
   input wire logic c_clk_i,                     // output clock level
   input wire logic c_n_clk_i,                   // complementary output clock level
   input wire logic pll_bypass_n_i,              // low runs without the loop
   output logic [dsp_pkg::DATA_W-1:0] q_o,       // read data
   output logic q_oe_o,                          // read data driven
   output logic q_from_k_o,                      // read data timed by K pair
   output logic pll_locked_o,                    // loop locked or bypassed, sys domain
   output logic write_refused_o                  // write dropped, buffer level above FIFO_ROOM
);
   import dsp_pkg::*;

   // =====================================================
   // lock tracking, sys domain
   logic byp_m;
   logic byp_s;
   logic al_m;
   logic al_s;
   logic al_d;
   logic byp_on;
   logic alive_edge;
   logic clk_stable;
   logic [GAP_CNT_W-1:0] gap_cnt;
   logic [LOCK_CNT_W-1:0] lock_cnt;
   logic [LOCK_CNT_W-1:0] next_lock_cnt;
   dsp_lock_e lock_state;
   dsp_lock_e next_lock_state;
   logic [ALIVE_DIV_W-1:0] alive_div;

   always_ff @(posedge sys_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         byp_m <= 1'b1;
         byp_s <= 1'b1;
         al_m <= 1'b0;
         al_s <= 1'b0;
         al_d <= 1'b0;
      end
      else
      begin
         byp_m <= pll_bypass_n_i;
         byp_s <= byp_m;
         al_m <= alive_div[ALIVE_DIV_W-1];
         al_s <= al_m;
         al_d <= al_s;
      end
   end

   assign byp_on = !byp_s;
   assign alive_edge = al_s ^ al_d;
   assign clk_stable = (gap_cnt < GAP_CYC);

   // K edges missing for GAP_CYC system cycles restart the lock wait, so outside bypass a stop forces a relock
   always_ff @(posedge sys_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         gap_cnt <= GAP_CYC;
      else if (alive_edge)
         gap_cnt <= '0;
      else if (clk_stable)
         gap_cnt <= gap_cnt + 1'b1;
   end

   always_comb
   begin
      next_lock_state = lock_state;
      next_lock_cnt = '0;
      case (lock_state)
         LK_WAIT:
            if (byp_on)
               next_lock_state = LK_BYPASS;
            else if (alive_edge)
               next_lock_state = LK_COUNT;
         LK_COUNT:
         begin
            next_lock_cnt = (lock_cnt == LOCK_CYC) ? lock_cnt : lock_cnt + 1'b1;
            if (byp_on)
               next_lock_state = LK_BYPASS;
            else if (!clk_stable)
               next_lock_state = LK_WAIT;
            else if (lock_cnt == LOCK_CYC)
               next_lock_state = LK_LOCKED;
         end
         LK_LOCKED:
            if (byp_on)
               next_lock_state = LK_BYPASS;
            else if (!clk_stable)
               next_lock_state = LK_WAIT;
         LK_BYPASS:
            if (!byp_on)
               next_lock_state = LK_WAIT;
         default:
            next_lock_state = LK_WAIT;
      endcase
   end

   always_ff @(posedge sys_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         lock_state <= LK_WAIT;
         lock_cnt <= '0;
      end
      else
      begin
         lock_state <= next_lock_state;
         lock_cnt <= next_lock_cnt;
      end
   end

   always_ff @(posedge sys_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         pll_locked_o <= 1'b0;
      else
         pll_locked_o <= (next_lock_state == LK_LOCKED) || (next_lock_state == LK_BYPASS);
   end

   a_lock_wait_time: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      $rose(pll_locked_o) && !byp_on |-> lock_cnt == LOCK_CYC)
      else $error("lock declared before the wait elapsed");
   a_bypass_lock: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      byp_on ##1 byp_on |=> pll_locked_o)
      else $error("bypass did not count as locked");
   a_gap_unlock: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      !byp_on && !clk_stable ##1 !byp_on |=> !pll_locked_o)
      else $error("lock kept without input clock");

   // =====================================================
   // link domain: reset, lock and output-clock crossings
   logic k_rst_m;
   logic k_rst;
   logic lk_m;
   logic k_locked;
   logic [1:0] c_m;
   logic [1:0] c_s;

   always_ff @(posedge k_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         k_rst_m <= 1'b1;
         k_rst <= 1'b1;
      end
      else
      begin
         k_rst_m <= 1'b0;
         k_rst <= k_rst_m;
      end
   end

   always_ff @(posedge k_clk_i or posedge k_rst)
   begin
      if (k_rst)
      begin
         lk_m <= 1'b0;
         k_locked <= 1'b0;
         c_m <= 2'h0;
         c_s <= 2'h0;
         alive_div <= '0;
      end
      else
      begin
         lk_m <= pll_locked_o;
         k_locked <= lk_m;
         c_m <= {c_clk_i, c_n_clk_i};
         c_s <= c_m;
         alive_div <= alive_div + 1'b1;
      end
   end

   // both output clocks parked high: the K pair times the read data
   assign q_from_k_o = &c_s;

   // =====================================================
   // command capture at K rise
   logic [LANES-1:0] lane_mask;
   logic [LANES-1:0] lane_en;
   logic [FIFO_LVL_W-1:0] fifo_level;
   logic room;
   logic acc_rd;
   logic acc_wr;
   logic c_rd;
   logic c_wr;
   logic [ADDR_W-1:0] c_addr;

   assign lane_mask = wide_org_p ? WIDE_LANE_MASK : NARROW_LANE_MASK;
   assign lane_en = ~{lane3_write_n_i, lane2_write_n_i, lane1_write_n_i, lane0_write_n_i}
                    & lane_mask;
   assign room = (fifo_level <= FIFO_ROOM);
   assign acc_rd = k_locked && !cmd_i.load_strobe_n && cmd_i.read_write;
   assign acc_wr = k_locked && !cmd_i.load_strobe_n && !cmd_i.read_write && room;

   always_ff @(posedge k_clk_i or posedge k_rst)
   begin
      if (k_rst)
      begin
         c_rd <= 1'b0;
         c_wr <= 1'b0;
         c_addr <= '0;
         write_refused_o <= 1'b0;
      end
      else
      begin
         c_rd <= acc_rd;
         c_wr <= acc_wr;
         if (acc_rd || acc_wr)
            c_addr <= cmd_i.addr;
         write_refused_o <= k_locked && !cmd_i.load_strobe_n && !cmd_i.read_write && !room;
      end
   end

   // =====================================================
   // write words: first at K rise, second at K# rise
   logic w_pend;
   dsp_wr_s w_hold;
   logic [DATA_W-1:0] w_d1;
   logic [LANES-1:0] w_en1;
   dsp_wr_s push_word;
   dsp_wr_s head;
   logic head_valid;
   logic drain;
   logic fifo_in_ready;

   always_ff @(posedge k_clk_i or posedge k_rst)
   begin
      if (k_rst)
      begin
         w_pend <= 1'b0;
         w_hold <= '0;
      end
      else
      begin
         w_pend <= c_wr;
         if (c_wr)
         begin
            w_hold.addr <= c_addr;
            w_hold.d0 <= d_i;
            w_hold.en0 <= lane_en;
         end
      end
   end

   always_ff @(negedge k_clk_i or posedge k_rst)
   begin
      if (k_rst)
      begin
         w_d1 <= '0;
         w_en1 <= '0;
      end
      else if (w_pend)
      begin
         w_d1 <= d_i;
         w_en1 <= lane_en;
      end
   end

   assign push_word = '{addr: w_hold.addr, d0: w_hold.d0, en0: w_hold.en0,
                        d1: w_d1, en1: w_en1};

   dsp_fifo #(
      .WIDTH($bits(dsp_wr_s)),
      .DEPTH(FIFO_DEPTH)
   ) u_wr_fifo (
      .clk_i(k_clk_i),
      .rst_i(k_rst),
      .in_valid_i(w_pend),
      .in_ready_o(fifo_in_ready),
      .in_data_i(push_word),
      .out_valid_o(head_valid),
      .out_ready_i(!c_rd),
      .out_data_o(head),
      .level_o(fifo_level)
   );

   // the array has one access per K cycle; a read takes it and stalls the drain
   assign drain = head_valid && !c_rd;

   // =====================================================
   // storage: no reset, contents survive a clock stop
   logic [DATA_W-1:0] mem_even [2**store_aw_p];
   logic [DATA_W-1:0] mem_odd [2**store_aw_p];

   always_ff @(posedge k_clk_i)
   begin
      if (drain)
         for (int i = 0; i < LANES; i++)
         begin
            if (head.en0[i])
               mem_even[head.addr[store_aw_p-1:0]][i*LANE_W +: LANE_W] <=
                  head.d0[i*LANE_W +: LANE_W];
            if (head.en1[i])
               mem_odd[head.addr[store_aw_p-1:0]][i*LANE_W +: LANE_W] <=
                  head.d1[i*LANE_W +: LANE_W];
         end
   end

   // =====================================================
   // read pipeline and DDR output
   logic s1_rd;
   logic [DATA_W-1:0] rd0;
   logic [DATA_W-1:0] rd1;
   logic oe_rise;
   logic oe_fall;
   logic [DATA_W-1:0] q_rise;
   logic [DATA_W-1:0] q_fall;

   always_ff @(posedge k_clk_i or posedge k_rst)
   begin
      if (k_rst)
      begin
         s1_rd <= 1'b0;
         rd0 <= '0;
         rd1 <= '0;
      end
      else
      begin
         s1_rd <= c_rd;
         if (c_rd)
         begin
            rd0 <= mem_even[c_addr[store_aw_p-1:0]];
            rd1 <= mem_odd[c_addr[store_aw_p-1:0]];
         end
      end
   end

   always_ff @(negedge k_clk_i or posedge k_rst)
   begin
      if (k_rst)
      begin
         oe_fall <= 1'b0;
         q_fall <= '0;
      end
      else
      begin
         oe_fall <= s1_rd;
         q_fall <= s1_rd ? rd0 : '0;
      end
   end

   always_ff @(posedge k_clk_i or posedge k_rst)
   begin
      if (k_rst)
      begin
         oe_rise <= 1'b0;
         q_rise <= '0;
      end
      else
      begin
         oe_rise <= s1_rd;
         q_rise <= s1_rd ? rd1 : '0;
      end
   end

   // C pair is mesochronous with K; edge alignment to C is left to the pads
   assign q_o = k_clk_i ? q_rise : q_fall;
   assign q_oe_o = k_clk_i ? oe_rise : oe_fall;

   sequence s_read_taken;
      acc_rd;
   endsequence
   sequence s_write_taken;
      acc_wr ##1 1'b1;
   endsequence

   a_read_first_word: assert property (@(posedge k_clk_i) disable iff (k_rst)
      s_read_taken |-> ##2 (oe_fall && q_fall == rd0))
      else $error("first read word not driven on the K# rise");
   a_read_second_word: assert property (@(posedge k_clk_i) disable iff (k_rst)
      s_read_taken |-> ##2 1'b1 ##1 (oe_rise && q_rise == $past(rd1)))
      else $error("second read word not driven a cycle later");
   a_idle_high_z: assert property (@(posedge k_clk_i) disable iff (k_rst)
      !$past(acc_rd, 3) && !$past(acc_rd, 2) |-> !oe_rise && !oe_fall)
      else $error("outputs driven without a read");
   a_reset_high_z: assert property (@(posedge k_clk_i)
      $fell(k_rst) |-> !oe_rise && !oe_fall && !s1_rd)
      else $error("outputs driven at power-up");
   a_write_burst: assert property (@(posedge k_clk_i) disable iff (k_rst)
      s_write_taken |-> ##1 (w_pend && push_word.addr == $past(cmd_i.addr, 2)
      && push_word.d0 == $past(d_i)))
      else $error("write burst not assembled from address and first word");
   a_lane_select: assert property (@(posedge k_clk_i) disable iff (k_rst)
      w_pend |-> (push_word.en0 & ~lane_mask) == '0 && (push_word.en1 & ~lane_mask) == '0)
      else $error("lane outside the organisation enabled");
   a_unlocked_ignored: assert property (@(posedge k_clk_i) disable iff (k_rst)
      !k_locked |=> !c_rd && !c_wr)
      else $error("command taken before lock");
   a_buffer_room: assert property (@(posedge k_clk_i) disable iff (k_rst)
      w_pend |-> fifo_in_ready)
      else $error("write burst pushed into a full buffer");
endmodule // dsp_port

`default_nettype wire

// [tb/dsp_ctrl_model.sv]
// Purpose: controller-side model driving the link clocks, commands and write bursts
// Assumes: the bench queues commands; one is issued per K cycle, in order
// Notes: idle lines carry a changing pattern so stale values never pass for data
`timescale 1ns/100ps
`default_nettype none
module dsp_ctrl_model (
   output logic k_clk_o,                       // true input clock
   output logic c_clk_o,                       // output clock
   output logic c_n_clk_o,                     // complementary output clock
   output dsp_pkg::dsp_cmd_s cmd_o,            // strobe, select, address
   output logic [dsp_pkg::DATA_W-1:0] d_o,     // write data
   output logic [3:0] lane_n_o                 // lane enables, low
);
   import dsp_pkg::*;
   // op layout: rw, addr[20], w0[36], w1[36], en0[4], en1[4]
   logic [100:0] ops [$];
   logic [100:0] nxt, cur;
   logic nxt_v, cur_v, k_run, c_hold;
   // =====================================================
   // clocks
   initial
   begin
      k_clk_o = 1'b0;
      k_run = 1'b1;
      c_hold = 1'b0;
      nxt_v = 1'b0;
      cur_v = 1'b0;
      cmd_o = {1'b1, 1'b0, 20'h00000};
      d_o = '0;
      lane_n_o = 4'hf;
   end
   always
   begin
      #7.5;
      k_clk_o = k_run ? ~k_clk_o : 1'b0; // steady period, parked low
   end
   // stopped: K, C and C# all low together
   assign c_clk_o = c_hold | k_clk_o;
   assign c_n_clk_o = c_hold | (k_run & ~k_clk_o);
   // =====================================================
   // command and data issue
   always @(negedge k_clk_o)
   begin
      d_o <= cur_v ? cur[79:44] : ~d_o; // first word, ahead of K rise
      lane_n_o <= cur_v ? cur[7:4] : ~lane_n_o;
      nxt_v = (ops.size() > 0);
      if (nxt_v)
      begin
         nxt = ops.pop_front();
         cmd_o <= {1'b0, nxt[100], nxt[99:80]};
      end
      else
      begin
         cmd_o <= {1'b1, ~cmd_o.read_write, ~cmd_o.addr};
      end
   end
   always @(posedge k_clk_o)
   begin
      if (cur_v)
      begin
         d_o <= cur[43:8]; // second word, ahead of K fall
         lane_n_o <= cur[3:0];
      end
      cur = nxt;
      cur_v = nxt_v & ~nxt[100];
   end
endmodule // dsp_ctrl_model
`default_nettype wire

// [tb/ddr_sram_two_word_burst_port_tb.sv]
// Purpose: self-checking bench for the burst port, its lock tracking and write buffer
// Assumes: controller model issues queued commands, one per K cycle
// Notes: expected store contents are kept here lane by lane
`timescale 1ns/100ps
`default_nettype none
module ddr_sram_two_word_burst_port_tb;
   import dsp_pkg::*;
   logic sys_clk_i, sys_rst_i, pll_bypass_n_i, live;
   logic k_clk, c_clk, c_n_clk, q_oe, q_from_k, locked, refused;
   dsp_cmd_s cmd;
   logic [DATA_W-1:0] d, q;
   logic [3:0] lane_n;
   logic [2:0] rd;
   logic [5:0] ra [3];
   logic [DATA_W-1:0] mem_e [64];
   logic [DATA_W-1:0] mem_o [64];
   int err_count, checked;
   // =====================================================
   // instances
   dsp_ctrl_model dsp_ctrl_model_i (.k_clk_o(k_clk), .c_clk_o(c_clk), .c_n_clk_o(c_n_clk),
      .cmd_o(cmd), .d_o(d), .lane_n_o(lane_n));
   dsp_port #(.wide_org_p(1'b1), .store_aw_p(6)) dsp_port_i (.sys_clk_i(sys_clk_i),
      .sys_rst_i(sys_rst_i), .k_clk_i(k_clk), .cmd_i(cmd), .d_i(d),
      .lane0_write_n_i(lane_n[0]), .lane1_write_n_i(lane_n[1]), .lane2_write_n_i(lane_n[2]),
      .lane3_write_n_i(lane_n[3]), .c_clk_i(c_clk), .c_n_clk_i(c_n_clk),
      .pll_bypass_n_i(pll_bypass_n_i), .q_o(q), .q_oe_o(q_oe), .q_from_k_o(q_from_k),
      .pll_locked_o(locked), .write_refused_o(refused));
   initial sys_clk_i = 1'b0;
   always #50 sys_clk_i = ~sys_clk_i;
   // =====================================================
   // helpers
   task automatic chk(input string nm, input logic [35:0] e, input logic [35:0] g);
      checked++;
      if (g !== e)
      begin
         err_count++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   task end_sim;
      if (err_count == 0 && checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   function automatic logic [35:0] mrg(logic [35:0] o, logic [35:0] n, logic [3:0] en_n);
      for (int i = 0; i < 4; i++)
         if (!en_n[i])
            o[9*i +: 9] = n[9*i +: 9];
      return o;
   endfunction
   task automatic wr(input logic [5:0] a, input logic [35:0] w0, w1, input logic [3:0] e0, e1);
      mem_e[a] = mrg(mem_e[a], w0, e0);
      mem_o[a] = mrg(mem_o[a], w1, e1);
      dsp_ctrl_model_i.ops.push_back({1'b0, 14'h0000, a, w0, w1, e0, e1});
   endtask
   task automatic rd_op(input logic [5:0] a);
      dsp_ctrl_model_i.ops.push_back({1'b1, 14'h0000, a, 72'h0, 8'hff});
   endtask
   task automatic drain;
      while (dsp_ctrl_model_i.ops.size() > 0)
         @(posedge k_clk);
      repeat (8) @(posedge k_clk);
   endtask
   task automatic wait_lock(input int lim);
      int n;
      n = 0;
      while (locked !== 1'b1 && n < lim)
      begin
         @(negedge sys_clk_i);
         n++;
      end
      chk("pll_locked_o", 1, locked);
      repeat (4) @(posedge k_clk);
      live = 1'b1;
   endtask
   // =====================================================
   // read data monitor: even word in K-low half, odd word in next K-high half
   always @(posedge k_clk)
   begin
      rd <= {rd[1:0], live & ~cmd.load_strobe_n & cmd.read_write};
      ra[0] <= cmd.addr[5:0];
      ra[1] <= ra[0];
      ra[2] <= ra[1];
      #2;
      chk("q_oe_o high half", rd[2], q_oe);
      if (rd[2])
         chk("q_o odd word", mem_o[ra[2]], q);
      if (live)
         chk("write_refused_o", 0, refused);
   end
   always @(negedge k_clk)
   begin
      #2;
      chk("q_oe_o low half", rd[1], q_oe);
      if (rd[1])
         chk("q_o even word", mem_e[ra[1]], q);
   end
   // =====================================================
   // scenarios
   task t_power;
      repeat (190) @(negedge sys_clk_i);
      rd_op(6'h01); // ignored before lock
      chk("pll_locked_o early", 0, locked);
      wait_lock(60);
   endtask
   task t_wr_rd;
      for (int a = 0; a < 4; a++)
         wr(6'(a), 36'h123456789 ^ 36'(a), 36'h9abcdef01 + 36'(a), 4'h0, 4'h0);
      drain;
      for (int a = 0; a < 4; a++)
         rd_op(6'(a)); // back to back
      drain;
   endtask
   task t_lanes;
      for (int i = 0; i < 5; i++)
         wr(6'(8 + i), 36'h000000000, 36'h000000000, 4'h0, 4'h0);
      drain;
      for (int i = 0; i < 4; i++)
         wr(6'(8 + i), 36'hfffffffff, 36'h5a5a5a5a5, ~(4'h1 << i), ~(4'h8 >> i));
      wr(6'h0c, 36'hfffffffff, 36'hfffffffff, 4'hf, 4'hf); // writes nothing
      drain;
      for (int i = 0; i < 5; i++)
         rd_op(6'(8 + i));
      drain;
   endtask
   task t_c_hold;
      dsp_ctrl_model_i.c_hold = 1'b1;
      repeat (6) @(posedge k_clk);
      chk("q_from_k_o held", 1, q_from_k);
      rd_op(6'h02);
      drain;
      dsp_ctrl_model_i.c_hold = 1'b0;
      repeat (6) @(posedge k_clk);
      chk("q_from_k_o free", 0, q_from_k);
   endtask
   task t_stop;
      live = 1'b0;
      dsp_ctrl_model_i.k_run = 1'b0;
      repeat (20) @(negedge sys_clk_i);
      chk("pll_locked_o stopped", 0, locked);
      dsp_ctrl_model_i.k_run = 1'b1;
      wait_lock(260);
      for (int a = 0; a < 4; a++)
         rd_op(6'(a));
      drain;
   endtask
   task t_bypass;
      live = 1'b0;
      @(negedge sys_clk_i);
      pll_bypass_n_i = 1'b0;
      sys_rst_i = 1'b1;
      repeat (5) @(negedge sys_clk_i);
      sys_rst_i = 1'b0;
      wait_lock(10);
      for (int i = 0; i < 4; i++)
         rd_op(6'(8 + i));
      drain;
   endtask
   // write burst parked in the buffer while back-to-back reads hold the array
   task t_buffer;
      wr(6'h10, 36'h0f0f0f0f0, 36'h3c3c3c3c3, 4'h0, 4'h0);
      for (int a = 0; a < 6; a++)
         rd_op(6'(a % 4));
      while (dsp_ctrl_model_i.ops.size() > 0)
         @(posedge k_clk);
      #1;
      chk("buffer level stalled", 1, dsp_port_i.fifo_level);
      chk("buffer head valid", 1, dsp_port_i.head_valid);
      chk("write_refused_o stalled", 0, refused);
      repeat (2) @(posedge k_clk);
      #1;
      chk("buffer level drained", 0, dsp_port_i.fifo_level);
      chk("buffer head valid drained", 0, dsp_port_i.head_valid);
      rd_op(6'h10);
      drain;
   endtask
   // =====================================================
   // main sequence and watchdog
   initial
   begin
      err_count = 0;
      checked = 0;
      live = 1'b0;
      rd = 3'h0;
      sys_rst_i = 1'b1;
      pll_bypass_n_i = 1'b1;
      repeat (5) @(negedge sys_clk_i);
      sys_rst_i = 1'b0;
      t_power;
      t_wr_rd;
      t_lanes;
      t_c_hold;
      t_stop;
      t_bypass;
      t_buffer;
      end_sim;
   end
   initial
   begin
      #1ms;
      err_count++;
      end_sim;
   end
endmodule // ddr_sram_two_word_burst_port_tb
`default_nettype wire
